// ---- verilog/exc_class_consts.svh ----
/*
  Constants for the exception class encoder: class codes, syndrome field
  positions, coprocessor numbers and reset value.
  Assumes it is included by its bare name ahead of the package and module.
*/
`ifndef EXC_CLASS_CONSTS_SVH
`define EXC_CLASS_CONSTS_SVH

// class codes
`define CLS_UNKNOWN      6'h00
`define CLS_WAIT_HINT    6'h01
`define CLS_CP15_REG     6'h03
`define CLS_CP15_PAIR    6'h04
`define CLS_CP14_REG     6'h05
`define CLS_CP14_LDST    6'h06
`define CLS_FP_ACCESS    6'h07
`define CLS_FP_ID_READ   6'h08
`define CLS_PAUTH        6'h09
`define CLS_LS64         6'h0A
`define CLS_CP14_PAIR_RD 6'h0C
`define CLS_BRANCH_TGT   6'h0D
`define CLS_ILLEGAL      6'h0E
`define CLS_SV_CALL_32   6'h11
`define CLS_HV_CALL_32   6'h12
`define CLS_SM_CALL_32   6'h13
`define CLS_SV_CALL_64   6'h15
`define CLS_HV_CALL_64   6'h16
`define CLS_SM_CALL_64   6'h17
`define CLS_SYSREG       6'h18

// number of qualified cause entries in the priority chain
`define CAUSE_COUNT      20

// coprocessor numbers
`define COPROC_NUM_HI    4'hF
`define COPROC_NUM_LO    4'hE

// syndrome register layout
`define SYN_RES_HI       63
`define SYN_RES_LO       56
`define SYN_SPEC2_HI     55
`define SYN_SPEC2_LO     32
`define SYN_CLASS_HI     31
`define SYN_CLASS_LO     26
`define SYN_LEN_BIT      25
`define SYN_SPEC_HI      24
`define SYN_SPEC_LO      0
`define SYN_WRITE_MASK   64'h00FF_FFFF_FFFF_FFFF
`define SYN_RESET        64'h0000_0000_0000_0000

`endif

// ---- verilog/exc_class_pkg.sv ----
/*
  Types shared by the exception class encoder.
  Assumes exc_class_consts.svh is on the include path.
*/
`include "exc_class_consts.svh"

package exc_class_pkg;
  typedef logic [5:0] class_code_t;
  typedef logic [63:0] syndrome_t;
  typedef logic [3:0] coproc_num_t;
endpackage : exc_class_pkg

// ---- verilog/exception_class_encoder.sv ----
/*
  Exception class encoder and hypervisor-level syndrome register.
  Assumes the core's trap detection logic presents one cause flag with
  exc_take in the cycle the exception is taken, all inputs synchronous
  to clk_sys, and software reaching the register through the system
  register read/write port below.
*/
`timescale 1ns/1ps
`default_nettype none
`include "exc_class_consts.svh"

// Function
// - class code held in syndrome bits 31:26
// - unknown or unreported reason gives class zero
// - wait hint class; failed condition raises nothing
// - coproc 1111 register move class when supported
// - coproc 1111 pair move class when supported
// - coproc 1110 register move class when supported
// - coproc load/store class when supported
// - fp/vector trap class, else unknown
// - fp id-group sysreg read class when supported
// - pointer auth trap class when enable is 0
// - 64-byte load/store exception class
// - coproc 1110 pair read class when supported
// - branch target exception class
// - illegal execution state class
// - 32-bit supervisor call only under general trap
// - 32-bit hypervisor call when not disabled
// - 32-bit monitor call only under secure-call trap
// - 64-bit supervisor call class
// - 64-bit hypervisor call when not disabled
// - 64-bit monitor call only under secure-call trap
// - 64-bit system register trap class
// - 64-bit register, bits 63:56 read zero
// - contents clear to the reset value (zero) on exception return with no recorded take or software write in the same cycle
module exception_class_encoder
  import exc_class_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // feature presence
  input wire logic has_32bit_state,
  input wire logic has_pointer_auth,
  input wire logic has_64byte_access,
  input wire logic has_branch_target,
  // exception take
  input wire logic exc_take,
  input wire logic exc_return,
  // causes
  input wire logic cause_wait_for_hint,
  input wire logic wait_cond_failed,
  input wire logic cause_coproc_reg,
  input wire logic cause_coproc_pair,
  input wire logic coproc_is_read,
  input wire coproc_num_t coproc_num,
  input wire logic cause_coproc_ldst,
  input wire logic cause_fp_access,
  input wire logic fp_unit_absent,
  input wire logic cause_fp_sysreg_id,
  input wire logic cause_pointer_auth,
  input wire logic cause_64byte_access,
  input wire logic cause_branch_target,
  input wire logic cause_illegal_state,
  input wire logic cause_supervisor_call_32,
  input wire logic cause_hypervisor_call_32,
  input wire logic cause_secure_monitor_call_32,
  input wire logic cause_supervisor_call_64,
  input wire logic cause_hypervisor_call_64,
  input wire logic cause_secure_monitor_call_64,
  input wire logic cause_sysreg_trap,
  input wire logic cause_unknown,
  // trap controls
  input wire logic trap_general_exceptions,
  input wire logic secure_call_trap,
  input wire logic hypervisor_call_disabled,
  input wire logic secure_monitor_call_disabled,
  input wire logic pointer_auth_enable_hyp,
  input wire logic pointer_auth_enable_mon,
  // rest of the syndrome
  input wire logic instr_len_32,
  input wire logic [24:0] class_specific_syndrome,
  input wire logic [23:0] class_specific_syndrome2,
  // system register port
  input wire logic sysreg_wr,
  input wire syndrome_t sysreg_wdata,
  output syndrome_t hyp_syndrome_register,
  // status
  output class_code_t exception_class_code,
  output logic exc_recorded,
  output logic exc_dropped
);

  // register state
  syndrome_t syn_r;
  syndrome_t syn_nxt;
  logic rec_r;
  logic drop_r;

  // coprocessor number decode
  wire num_hi = (coproc_num == `COPROC_NUM_HI);
  wire num_lo = (coproc_num == `COPROC_NUM_LO);

  // causes that never reach this register: the take is dropped and the
  // register keeps what it held, so software still sees the last real take
  wire wait_failed_take = cause_wait_for_hint & wait_cond_failed;

  // a 32-bit supervisor call is taken here only because of the general trap
  wire svc32_untrapped = cause_supervisor_call_32 & ~trap_general_exceptions;

  // monitor calls are taken here only because of the secure-call trap
  wire smc32_untrapped = cause_secure_monitor_call_32 & ~secure_call_trap;
  wire smc64_untrapped = cause_secure_monitor_call_64 & ~secure_call_trap;

  // any of the above suppresses the write for this take
  wire drop_any = wait_failed_take | svc32_untrapped | smc32_untrapped | smc64_untrapped;

  // take qualification: exactly one of these is high for each exc_take pulse
  wire take_drop = exc_take & drop_any;
  wire take_record = exc_take & ~drop_any;

  // pointer auth traps only while one of the two level enables is clear
  wire pauth_blocked = ~(pointer_auth_enable_hyp & pointer_auth_enable_mon);

  // fp trap falls back to unknown under the general trap or a missing unit
  wire fp_reportable = ~trap_general_exceptions & ~fp_unit_absent;

  // per-cause qualification: a cause whose feature is absent or whose
  // condition is not met qualifies nothing and ends up as class zero

  // explicit unknown from the trap logic
  wire v_unknown = cause_unknown;
  // trapped wait hint
  wire v_wait = cause_wait_for_hint;

  // coprocessor traps only exist with 32-bit state
  // register move on coprocessor 1111
  wire v_cp_reg_hi = cause_coproc_reg & has_32bit_state & num_hi;
  // register-pair move on coprocessor 1111
  wire v_cp_pair_hi = cause_coproc_pair & has_32bit_state & num_hi;
  // register move on coprocessor 1110
  wire v_cp_reg_lo = cause_coproc_reg & has_32bit_state & num_lo;
  // coprocessor load or store, debug transfer data only
  wire v_cp_ldst = cause_coproc_ldst & has_32bit_state;

  // fp, vector or matrix access trap
  wire v_fp = cause_fp_access & fp_reportable;
  // fp system-register read from the id group trap
  wire v_fp_id = cause_fp_sysreg_id & has_32bit_state;

  // pointer auth instruction with an enable clear
  wire v_pauth = cause_pointer_auth & has_pointer_auth & pauth_blocked;
  // 64-byte load or store
  wire v_64byte = cause_64byte_access & has_64byte_access;
  // only the read form of the 1110 pair move has a class of its own
  wire v_cp_pair_lo = cause_coproc_pair & has_32bit_state & num_lo & coproc_is_read;

  // branch target check failure
  wire v_btarget = cause_branch_target & has_branch_target;
  // illegal execution state
  wire v_illegal = cause_illegal_state;

  // 32-bit calls
  // 32-bit supervisor call
  wire v_svc32 = cause_supervisor_call_32 & has_32bit_state;
  // 32-bit hypervisor call unless calls are disabled
  wire v_hvc32 = cause_hypervisor_call_32 & has_32bit_state & ~hypervisor_call_disabled;
  // 32-bit monitor call unless calls are disabled
  wire v_smc32 = cause_secure_monitor_call_32 & has_32bit_state & ~secure_monitor_call_disabled;

  // 64-bit calls
  // 64-bit supervisor call
  wire v_svc64 = cause_supervisor_call_64;
  // 64-bit hypervisor call unless calls are disabled
  wire v_hvc64 = cause_hypervisor_call_64 & ~hypervisor_call_disabled;
  // 64-bit monitor call unless calls are disabled
  wire v_smc64 = cause_secure_monitor_call_64 & ~secure_monitor_call_disabled;

  // trapped system register move or system instruction
  wire v_sysreg = cause_sysreg_trap;

  // qualified causes, lowest index wins; explicit unknown sits first so
  // a second flag raised beside it cannot turn it into a real class
  wire logic [`CAUSE_COUNT-1:0] cand_valid;
  assign cand_valid = {
    v_sysreg,
    v_smc64,
    v_hvc64,
    v_svc64,
    v_smc32,
    v_hvc32,
    v_svc32,
    v_illegal,
    v_btarget,
    v_cp_pair_lo,
    v_64byte,
    v_pauth,
    v_fp_id,
    v_fp,
    v_cp_ldst,
    v_cp_reg_lo,
    v_cp_pair_hi,
    v_cp_reg_hi,
    v_wait,
    v_unknown
  };

  // class code for each entry of cand_valid, same order
  wire class_code_t cand_code [`CAUSE_COUNT];
  assign cand_code = '{
    // unknown and wait hint
    `CLS_UNKNOWN,
    `CLS_WAIT_HINT,
    // coprocessor, fp, pointer auth, 64-byte, branch target and illegal state classes
    `CLS_CP15_REG,
    `CLS_CP15_PAIR,
    `CLS_CP14_REG,
    `CLS_CP14_LDST,
    `CLS_FP_ACCESS,
    `CLS_FP_ID_READ,
    `CLS_PAUTH,
    `CLS_LS64,
    `CLS_CP14_PAIR_RD,
    `CLS_BRANCH_TGT,
    `CLS_ILLEGAL,
    // calls and system register traps
    `CLS_SV_CALL_32,
    `CLS_HV_CALL_32,
    `CLS_SM_CALL_32,
    `CLS_SV_CALL_64,
    `CLS_HV_CALL_64,
    `CLS_SM_CALL_64,
    `CLS_SYSREG
  };

  // priority chain: the first qualified cause claims the code and masks
  // the rest, so two flags at once can never blend into an unlisted code
  wire logic [`CAUSE_COUNT:0] claimed;
  wire class_code_t code_acc [`CAUSE_COUNT+1];
  // chain starts unclaimed with class zero
  assign claimed[0] = 1'b0;
  assign code_acc[0] = `CLS_UNKNOWN;
  generate
    for (genvar gi = 0; gi < `CAUSE_COUNT; gi++) begin : g_prio
      // hit: this entry qualifies and nothing earlier did
      wire hit = cand_valid[gi] & ~claimed[gi];
      assign claimed[gi + 1] = claimed[gi] | cand_valid[gi];
      assign code_acc[gi + 1] = hit ? cand_code[gi] : code_acc[gi];
    end
  endgenerate

  // class picked for this take; nothing qualified leaves class zero
  wire class_code_t sel_class = code_acc[`CAUSE_COUNT];

  // whole syndrome for a recorded take, assembled in one word so class and
  // the class-specific fields always land in the same cycle
  wire syndrome_t take_word = syndrome_t'({class_specific_syndrome2, sel_class, instr_len_32,
    class_specific_syndrome}) & `SYN_WRITE_MASK;

  // software write: the reserved top byte reads back as zero
  wire syndrome_t write_word = sysreg_wdata & `SYN_WRITE_MASK;

  // next value: a recorded take beats a software write, which beats the
  // return clear; a return leaves the register at its reset value
  assign syn_nxt = take_record ? take_word :
    sysreg_wr ? write_word :
    exc_return ? `SYN_RESET : syn_r;

  // syndrome register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      syn_r <= `SYN_RESET;
    end else begin
      syn_r <= syn_nxt;
    end
  end

  // one-cycle pulse after a take that reached the register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rec_r <= 1'b0;
    end else begin
      rec_r <= take_record;
    end
  end

  // one-cycle pulse after a take that was suppressed
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      drop_r <= 1'b0;
    end else begin
      drop_r <= take_drop;
    end
  end

  // outputs straight from the flops
  assign hyp_syndrome_register = syn_r;
  assign exception_class_code = syn_r[`SYN_CLASS_HI:`SYN_CLASS_LO];

  // status pulses
  assign exc_recorded = rec_r;
  assign exc_dropped = drop_r;
endmodule : exception_class_encoder
`default_nettype wire

// ---- tb/exc_class_checker.sv ----
/* checker for the exception class encoder
   bound onto the encoder by name; watches its ports only */
`timescale 1ns/1ps
`default_nettype none
module exc_class_checker
  import exc_class_pkg::*;
(
  // watched ports
  input wire logic clk_sys, rst, exc_take, exc_return, sysreg_wr, instr_len_32,
  input wire logic cause_illegal_state, cause_supervisor_call_64, cause_fp_access, trap_general_exceptions,
  input wire logic [24:0] class_specific_syndrome,
  input wire syndrome_t sysreg_wdata, hyp_syndrome_register
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // class field of the register
  wire class_code_t cls = hyp_syndrome_register[31:26];
  a_reserved_zero: assert property (hyp_syndrome_register[63:56] == 8'h00)
    else $error("reserved bits set");
  a_illegal_class: assert property (exc_take && cause_illegal_state |=> cls == 6'h0e)
    else $error("bad illegal class");
  a_svc_wide_class: assert property (exc_take && cause_supervisor_call_64 |=> cls == 6'h15)
    else $error("bad supervisor class");
  a_fp_general: assert property (exc_take && cause_fp_access && trap_general_exceptions |=> cls == 6'h00)
    else $error("fp trap not unknown");
  a_fp_plain: assert property (exc_take && cause_fp_access && !trap_general_exceptions |=> cls == 6'h07)
    else $error("bad fp class");
  a_soft_write: assert property (sysreg_wr && !exc_take |=> hyp_syndrome_register ==
    ($past(sysreg_wdata) & 64'h00FF_FFFF_FFFF_FFFF)) else $error("bad register write");
  a_syndrome_together: assert property (exc_take && cause_illegal_state |=>
    hyp_syndrome_register[25:0] == {$past(instr_len_32), $past(class_specific_syndrome)}) else $error("syndrome apart");
  a_idle_hold: assert property (!exc_take && !sysreg_wr && !exc_return |=> $stable(hyp_syndrome_register))
    else $error("register moved");
  c_illegal: cover property (exc_take && cause_illegal_state);
  c_write: cover property (sysreg_wr);
  c_fp: cover property (exc_take && cause_fp_access && !trap_general_exceptions);
endmodule : exc_class_checker
bind exception_class_encoder exc_class_checker u_chk (.*);
`default_nettype wire

// ---- tb/exception_class_encoder_bench.sv ----
/* bench for the exception class encoder
   drives the trap side and register port directly */
`timescale 1ns/1ps
`default_nettype none
module exception_class_encoder_bench import exc_class_pkg::*; ;
  logic clk_sys = 0, rst = 1, exc_take = 0, exc_return = 0, sysreg_wr = 0, instr_len_32 = 1, wait_cond_failed = 0;
  logic coproc_is_read = 0, trap_general_exceptions = 1, secure_call_trap = 1, has_32bit_state = 1;
  logic has_pointer_auth = 1, has_64byte_access = 1, has_branch_target = 1, fp_unit_absent = 0;
  logic hypervisor_call_disabled = 0, secure_monitor_call_disabled = 0, pointer_auth_enable_hyp = 0;
  logic pointer_auth_enable_mon = 0, exc_recorded, exc_dropped;
  logic [17:0] c = 18'h0_0000;
  wire logic cause_wait_for_hint, cause_coproc_reg, cause_coproc_pair, cause_coproc_ldst, cause_fp_access;
  wire logic cause_fp_sysreg_id, cause_pointer_auth, cause_64byte_access, cause_branch_target, cause_illegal_state;
  wire logic cause_supervisor_call_32, cause_hypervisor_call_32, cause_secure_monitor_call_32, cause_unknown;
  wire logic cause_supervisor_call_64, cause_hypervisor_call_64, cause_secure_monitor_call_64, cause_sysreg_trap;
  coproc_num_t coproc_num = 4'h0;
  logic [24:0] class_specific_syndrome = 25'h0ab_cdef;
  logic [23:0] class_specific_syndrome2 = 24'h12_3456;
  syndrome_t sysreg_wdata = 64'hFFFF_FFFF_FFFF_FFFF, hyp_syndrome_register;
  class_code_t exception_class_code;
  int fails = 0, num_checks = 0;
  // entry: coproc number, read, cause index, expected class
  logic [15:0] tab [20] = '{16'h0001, 16'hF043, 16'hE845, 16'hF084, 16'hE88C, 16'h00C6, 16'h0100, 16'h0148,
    16'h0189, 16'h01CA, 16'h020D, 16'h024E, 16'h0291, 16'h02D2, 16'h0313, 16'h0355, 16'h0396, 16'h03D7,
    16'h0418, 16'h0440};
  assign {cause_unknown, cause_sysreg_trap, cause_secure_monitor_call_64, cause_hypervisor_call_64,
    cause_supervisor_call_64, cause_secure_monitor_call_32, cause_hypervisor_call_32, cause_supervisor_call_32,
    cause_illegal_state, cause_branch_target, cause_64byte_access, cause_pointer_auth, cause_fp_sysreg_id,
    cause_fp_access, cause_coproc_ldst, cause_coproc_pair, cause_coproc_reg, cause_wait_for_hint} = c;
  exception_class_encoder dut (.*);
  always #20 clk_sys = ~clk_sys;
  task chk(input syndrome_t seen, input syndrome_t exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task end_sim;
    if (fails == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  function syndrome_t syn(input class_code_t k);
    return {8'h00, class_specific_syndrome2, k, instr_len_32, class_specific_syndrome};
  endfunction : syn
  task take;
    @(posedge clk_sys);
    #1 exc_take = 1;
    @(posedge clk_sys);
    #1 exc_take = 0;
    c = 18'h0_0000;
  endtask : take
  // table of causes, then fp without general trap, failed wait, software write, return clear, disabled 64-bit hypervisor call
  initial begin
    repeat (10) @(posedge clk_sys);
    #1 rst = 0;
    foreach (tab[i]) begin
      {coproc_num, coproc_is_read} = tab[i][15:11];
      c[tab[i][10:6]] = 1;
      take;
      chk(hyp_syndrome_register, syn(tab[i][5:0]));
      chk(exception_class_code, tab[i][5:0]);
      chk(exc_recorded, 1'h1);
    end
    trap_general_exceptions = 0;
    c[4] = 1;
    take;
    chk(hyp_syndrome_register, syn(6'h07));
    c[0] = 1;
    wait_cond_failed = 1;
    take;
    chk(hyp_syndrome_register, syn(6'h07));
    chk(exc_dropped, 1'h1);
    chk(exc_recorded, 1'h0);
    sysreg_wr = 1;
    @(posedge clk_sys);
    #1 sysreg_wr = 0;
    chk(hyp_syndrome_register, 64'h00FF_FFFF_FFFF_FFFF);
    exc_return = 1;
    @(posedge clk_sys);
    #1 exc_return = 0;
    chk(hyp_syndrome_register, 64'h0000_0000_0000_0000);
    hypervisor_call_disabled = 1;
    wait_cond_failed = 0;
    c[14] = 1;
    take;
    chk(exception_class_code, 6'h00);
    end_sim;
  end
  // watchdog well past the roughly 60 cycles of tests
  initial begin
    #20us;
    fails++;
    end_sim;
  end
endmodule : exception_class_encoder_bench
`default_nettype wire
